// >>> design/pss_startup_sequencer.sv
// start-up sequencer: strap decode, default levels, tap-timed enables
// assumes strap pads and bus sense are asynchronous; the regulators and
// power gates are analog loads outside this block
`timescale 1ns/1ns
`default_nettype none

module pss_startup_sequencer
  import pss_pkg::*;
#(
  parameter int unsigned TAP_CYCLES_P = pss_pkg::TAP_CYCLES
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire pss_pkg::pss_strap_sense_t startup_strap_a,
  input  wire pss_pkg::pss_strap_sense_t startup_strap_b,
  input  wire logic                      bus_voltage_sense,
  input  wire logic                      backup_cell_valid,
  output pss_pkg::pss_pre_rails_t        pre_rails,
  output pss_pkg::pss_rail_en_t          rail_en,
  output pss_pkg::pss_level_t            rail_level,
  output logic [3:0]                     buck_pulse_skip,
  output logic                           power_gate_en,
  output logic [3:0]                     tap_index,
  output logic                           seq_done
);
  import pss_pkg::*;
  // ****************************************************************
  // helper functions
  // ****************************************************************
  // four-level pad to two-bit code; open when no comparator trips
  function automatic logic [1:0] decode_strap(pss_strap_sense_t s);
    if (s.at_gnd) begin
      return STRAP_GND;
    end else if (s.at_core) begin
      return STRAP_CORE;
    end else if (s.at_aon) begin
      return STRAP_AON;
    end
    return STRAP_OPEN;
  endfunction

  // tap at which a rail comes up; second strap selects the column
  function automatic logic [3:0] rail_tap(int idx, logic b_gnd);
    logic [3:0] t;
    case (idx)
      RAIL_BUCK_TWO:  t = 4'h0;
      RAIL_BUCK_FOUR: t = b_gnd ? 4'h2 : 4'h1;
      RAIL_IO_HIGH:   t = b_gnd ? 4'h3 : 4'h2;
      RAIL_GEN_B:     t = b_gnd ? 4'h1 : 4'h3;
      RAIL_BUCK_ONE:  t = b_gnd ? 4'h5 : 4'h4;
      RAIL_BUCK_THR:  t = b_gnd ? 4'h7 : 4'h5;
      RAIL_PLL:       t = 4'h6;
      RAIL_LOW_DIG:   t = b_gnd ? 4'h8 : 4'h7;
      RAIL_USB_XCVR:  t = b_gnd ? 4'h4 : 4'h9;
      RAIL_USB_PHY:   t = 4'h9;
      RAIL_CARD:      t = b_gnd ? 4'h3 : TAP_NEVER;
      RAIL_BOOST:     t = b_gnd ? 4'h4 : TAP_NEVER;
      default:        t = TAP_NEVER;
    endcase
    return t;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [4:0] {
    PSS_RESET = 5'b00001,  // just out of reset
    PSS_SYNC  = 5'b00010,  // let strap synchronisers settle
    PSS_PRE   = 5'b00100,  // pre-sequencer rails up
    PSS_TAPS  = 5'b01000,  // stepping through taps
    PSS_DONE  = 5'b10000   // sequence complete
  } pss_state_t;

  pss_state_t             state;        // sequencer state
  pss_state_t             next_state;   // combinational next state
  pss_strap_sense_t [1:0] strap_meta;   // first synchroniser stage
  pss_strap_sense_t [1:0] strap_sync;   // second synchroniser stage
  logic [1:0]             vbus_sync;    // bus sense synchroniser
  logic [1:0]             backup_sync;  // backup cell synchroniser
  logic [1:0]             sync_cnt;     // settle counter
  logic [1:0]             code_a;       // held first strap code
  logic [1:0]             code_b;       // held second strap code
  logic [TAP_CNT_W-1:0]   tap_cnt;      // cycles within current tap
  logic                   tap_tick;     // one-cycle tap advance enable
  logic                   b_gnd;        // second strap grounded
  pss_rail_en_t           allowed;      // rails this config may raise
  pss_level_t             next_level;   // decoded default levels
  assign b_gnd = (code_b == STRAP_GND);
  // power gates belong to software alone
  assign power_gate_en = 1'b0;
  // ****************************************************************
  // synchronisers
  // ****************************************************************
  // pads are asynchronous to mclk; second stage is the only reader
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta <= '0;
      strap_sync <= '0;
      vbus_sync  <= 2'h0;
      backup_sync <= 2'h0;
    end else begin
      strap_meta <= {startup_strap_b, startup_strap_a};
      strap_sync <= strap_meta;
      vbus_sync  <= {vbus_sync[0], bus_voltage_sense};
      backup_sync <= {backup_sync[0], backup_cell_valid};
    end
  end

  // ****************************************************************
  // state machine
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      PSS_RESET: next_state = PSS_SYNC;
      PSS_SYNC:  if (sync_cnt == SYNC_WAIT) begin
        next_state = PSS_PRE;
      end
      PSS_PRE:   next_state = PSS_TAPS;
      PSS_TAPS:  if (tap_tick && tap_index == TAP_LAST) begin
        next_state = PSS_DONE;
      end
      PSS_DONE:  next_state = PSS_DONE;
      default:   next_state = PSS_RESET;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= PSS_RESET;
    end else begin
      state <= next_state;
    end
  end
  // settle counter: covers the two synchroniser stages plus margin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_cnt <= 2'h0;
    end else if (state == PSS_SYNC) begin
      sync_cnt <= sync_cnt + 2'h1;
    end
  end

  // ****************************************************************
  // strap capture
  // ****************************************************************
  // caught once on leaving sync, then frozen until the next reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      code_a <= STRAP_GND;
      code_b <= STRAP_OPEN;
    end else if (state == PSS_SYNC && sync_cnt == SYNC_WAIT) begin
      code_a <= decode_strap(strap_sync[0]);
      code_b <= decode_strap(strap_sync[1]);
    end
  end

  // ****************************************************************
  // tap timer
  // ****************************************************************
  // a strap-free divider; each wrap is one tap advance
  assign tap_tick = (state == PSS_TAPS) &&
                    (tap_cnt == TAP_CNT_W'(TAP_CYCLES_P - 1));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tap_cnt <= '0;
    end else if (state != PSS_TAPS || tap_tick) begin
      tap_cnt <= '0;
    end else begin
      tap_cnt <= tap_cnt + TAP_CNT_W'(1);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tap_index <= 4'h0;
    end else if (tap_tick && tap_index != TAP_LAST) begin
      tap_index <= tap_index + 4'h1;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seq_done <= 1'b0;
    end else begin
      seq_done <= (next_state == PSS_DONE);
    end
  end

  // ****************************************************************
  // default levels and allowed set
  // ****************************************************************
  // levels in mV; a second strap other than ground uses the open column
  always_comb begin
    next_level = '0;
    allowed    = '0;
    for (int i = 0; i < NRAIL; i++) begin
      allowed[i] = (rail_tap(i, b_gnd) != TAP_NEVER);
    end
    next_level[RAIL_BUCK_FOUR] = 16'h0708;              // 1800
    next_level[RAIL_USB_XCVR]  = 16'h0CE4;              // 3300
    next_level[RAIL_USB_PHY]   = 16'h0A28;              // 2600
    next_level[RAIL_LOW_DIG]   = 16'h04E2;              // 1250
    next_level[RAIL_IO_HIGH]   = 16'h0AD7;              // 2775
    next_level[RAIL_GEN_B]     = 16'h0C4E;              // 3150
    if (b_gnd) begin
      next_level[RAIL_BUCK_ONE] = 16'h04B0;             // 1200
      next_level[RAIL_BUCK_TWO] = (code_a == STRAP_GND) ?
                                  16'h0546 : 16'h05AA;
      next_level[RAIL_BUCK_THR] = 16'h0708;             // 1800
      next_level[RAIL_BOOST]    = 16'h1388;             // 5000
      next_level[RAIL_PLL]      = 16'h05DC;             // 1500
      next_level[RAIL_CARD]     = 16'h0C4E;             // 3150
    end else begin
      // ground and core-rail first straps share the low core levels
      if (code_a == STRAP_GND || code_a == STRAP_CORE) begin
        next_level[RAIL_BUCK_ONE] = 16'h0307;           // 775
        next_level[RAIL_BUCK_TWO] = 16'h0401;           // 1025
      end else begin
        next_level[RAIL_BUCK_ONE] = 16'h041A;           // 1050
        next_level[RAIL_BUCK_TWO] = 16'h04C9;           // 1225
      end
      next_level[RAIL_BUCK_THR] = 16'h04B0;             // 1200
      next_level[RAIL_PLL]      = 16'h0708;             // 1800
      if (code_a == STRAP_OPEN || code_a == STRAP_CORE) begin
        next_level[RAIL_GEN_B] = 16'h0000;              // off
        allowed[RAIL_GEN_B]    = 1'b0;
      end
    end
  end

  // levels only become valid once the straps are held
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rail_level <= '0;
    end else if (state == PSS_PRE) begin
      rail_level <= next_level;
    end
  end

  // ****************************************************************
  // rail enables
  // ****************************************************************
  // sticky: once raised a rail stays on; software owns later changes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rail_en <= '0;
    end else if (state == PSS_TAPS) begin
      for (int i = 0; i < NRAIL; i++) begin
        if (allowed[i] && rail_tap(i, b_gnd) == tap_index) begin
          // unboosted usb waits for bus voltage at its tap only
          if (i == RAIL_USB_XCVR && !b_gnd) begin
            rail_en[i] <= rail_en[i] | vbus_sync[1];
          end else begin
            rail_en[i] <= 1'b1;
          end
        end
      end
    end
  end

  // bucks come up in pulse-skipping mode as they are enabled
  assign buck_pulse_skip = {rail_en[RAIL_BUCK_FOUR], rail_en[RAIL_BUCK_THR],
                            rail_en[RAIL_BUCK_TWO],
                            rail_en[RAIL_BUCK_ONE]};

  // ****************************************************************
  // pre-sequencer rails
  // ****************************************************************
  // always-on rail latches on; held while the backup cell is good
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_rails <= '0;
    end else if (state == PSS_PRE) begin
      pre_rails <= '1;
    end else if (!backup_sync[1] && state == PSS_DONE) begin
      pre_rails.always_on_digital_rail <= 1'b0;
    end
  end
endmodule // pss_startup_sequencer
`default_nettype wire

// >>> design/pss_pkg.sv
// constants, rail indices and carrier types of the start-up sequencer
// assumes a single 20 MHz start-up clock and pad sensing for the straps
package pss_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_FREQ_KHZ = 20000;  // start-up clock rate
  localparam int unsigned TAP_TIME_US  = 2000;   // one tap interval, us
  // cycles per tap, derived from the time and the clock rate
  localparam int unsigned TAP_CYCLES   = TAP_TIME_US * CLK_FREQ_KHZ / 1000;
  localparam int unsigned TAP_CNT_W    = 16;     // interval counter width
  localparam logic [3:0]  TAP_LAST     = 4'h9;   // final tap index
  localparam logic [3:0]  TAP_NEVER    = 4'hF;   // rail not sequenced
  localparam logic [1:0]  SYNC_WAIT    = 2'h3;   // cycles before sampling

  // ****************************************************************
  // strap codes
  // ****************************************************************
  localparam logic [1:0] STRAP_GND  = 2'h0;  // tied to ground
  localparam logic [1:0] STRAP_OPEN = 2'h1;  // left open
  localparam logic [1:0] STRAP_AON  = 2'h2;  // tied to always-on rail
  localparam logic [1:0] STRAP_CORE = 2'h3;  // tied to core reference

  // ****************************************************************
  // rail indices
  // ****************************************************************
  localparam int NRAIL          = 17;
  localparam int RAIL_BUCK_ONE  = 0;
  localparam int RAIL_BUCK_TWO  = 1;
  localparam int RAIL_BUCK_THR  = 2;
  localparam int RAIL_BUCK_FOUR = 3;
  localparam int RAIL_BOOST     = 4;
  localparam int RAIL_USB_XCVR  = 5;
  localparam int RAIL_USB_PHY   = 6;
  localparam int RAIL_PLL       = 7;
  localparam int RAIL_LOW_DIG   = 8;
  localparam int RAIL_IO_HIGH   = 9;
  localparam int RAIL_GEN_A     = 10;
  localparam int RAIL_GEN_B     = 11;
  localparam int RAIL_GEN_C     = 12;
  localparam int RAIL_CARD      = 13;
  localparam int RAIL_CAMERA    = 14;
  localparam int RAIL_VIDEO     = 15;
  localparam int RAIL_AUDIO     = 16;

  // ****************************************************************
  // carriers
  // ****************************************************************
  // pad sensing of one four-level strap; none set means left open
  typedef struct packed {
    logic at_gnd;   // pin pulled to ground
    logic at_aon;   // pin at always-on digital rail
    logic at_core;  // pin at core reference rail
  } pss_strap_sense_t;

  // rails raised before tap 0
  typedef struct packed {
    logic always_on_digital_rail;
    logic secure_clock_rail;
    logic core_reference_rail;
  } pss_pre_rails_t;

  typedef logic [NRAIL-1:0]       pss_rail_en_t;  // one bit per rail
  typedef logic [NRAIL-1:0][15:0] pss_level_t;    // default level, mV

endpackage : pss_pkg

// >>> testbench/pss_seq_chk.sv
// checker of the start-up sequencer, bound to its ports
// assumes one clock domain and reset values of zero
`timescale 1ns/1ns
`default_nettype none
module pss_seq_chk #(
  parameter int unsigned TAP_CYCLES_P = 8
) (
  input wire logic                      mclk,
  input wire logic                      rst_n,
  input wire pss_pkg::pss_strap_sense_t startup_strap_a,
  input wire pss_pkg::pss_strap_sense_t startup_strap_b,
  input wire logic                      bus_voltage_sense,
  input wire logic                      backup_cell_valid,
  input wire pss_pkg::pss_pre_rails_t   pre_rails,
  input wire pss_pkg::pss_rail_en_t     rail_en,
  input wire pss_pkg::pss_level_t       rail_level,
  input wire logic [3:0]                buck_pulse_skip,
  input wire logic                      power_gate_en,
  input wire logic [3:0]                tap_index,
  input wire logic                      seq_done
);
  import pss_pkg::*;
  // rails that only software may switch on
  localparam pss_rail_en_t SOFT_M = pss_rail_en_t'((1 << RAIL_GEN_A) |
    (1 << RAIL_GEN_C) | (1 << RAIL_CAMERA) | (1 << RAIL_VIDEO) |
    (1 << RAIL_AUDIO));
  logic [3:0]  last_tap;  // tap index one edge ago
  logic [15:0] gap;       // edges since the last tap change
  // ****************************************************************
  // tap spacing helper; wraps long after the last tap, harmless
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_tap <= 4'h0;
      gap      <= 16'h0;
    end else begin
      last_tap <= tap_index;
      gap      <= (tap_index != last_tap) ? 16'h1 : gap + 16'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // assertions
  // ****************************************************************
  pg_never_a: assert property (power_gate_en == 1'b0)
    else $error("power gate driven by the sequencer");
  soft_off_a: assert property ((rail_en & SOFT_M) == '0)
    else $error("software-only ldo enabled");
  skip_mode_a: assert property (
    buck_pulse_skip == {rail_en[RAIL_BUCK_FOUR], rail_en[RAIL_BUCK_THR],
    rail_en[RAIL_BUCK_TWO], rail_en[RAIL_BUCK_ONE]})
    else $error("buck not in pulse-skip mode");
  en_sticky_a: assert property (($past(rail_en) & ~rail_en) == '0)
    else $error("rail enable dropped");
  tap_step_a: assert property (tap_index != last_tap |->
    tap_index == last_tap + 4'h1 && tap_index <= TAP_LAST)
    else $error("tap skipped or past the end");
  tap_gap_a: assert property (tap_index != last_tap && last_tap != 4'h0
    |-> gap == 16'(TAP_CYCLES_P)) else $error("tap interval wrong");
  pre_first_a: assert property (rail_en != '0 |->
    pre_rails.secure_clock_rail && pre_rails.core_reference_rail)
    else $error("rail enabled before pre-rails");
  two_first_a: assert property (rail_en != '0 |->
    rail_en[RAIL_BUCK_TWO]) else $error("first rail is not buck two");
  boost_pair_a: assert property ($rose(rail_en[RAIL_BOOST]) |->
    rail_en[RAIL_USB_XCVR] && rail_en[RAIL_CARD] && tap_index == 4'h4)
    else $error("boost out of step");
  level_hold_a: assert property ($past(pre_rails.secure_clock_rail)
    |-> $stable(rail_level)) else $error("levels moved after capture");
  done_tap_a: assert property (seq_done |->
    tap_index == TAP_LAST && rail_en[RAIL_USB_PHY])
    else $error("done before the last tap");
  boost_c: cover property ($rose(rail_en[RAIL_BOOST]));
  xcvr_c: cover property ($rose(rail_en[RAIL_USB_XCVR]));
  done_c: cover property ($rose(seq_done));
endmodule // pss_seq_chk
bind pss_startup_sequencer pss_seq_chk #(.TAP_CYCLES_P(TAP_CYCLES_P)) chk (
  .mclk(mclk), .rst_n(rst_n), .startup_strap_a(startup_strap_a),
  .startup_strap_b(startup_strap_b), .bus_voltage_sense(bus_voltage_sense),
  .backup_cell_valid(backup_cell_valid), .pre_rails(pre_rails),
  .rail_en(rail_en), .rail_level(rail_level),
  .buck_pulse_skip(buck_pulse_skip), .power_gate_en(power_gate_en),
  .tap_index(tap_index), .seq_done(seq_done));
`default_nettype wire

// >>> testbench/pss_rail_model.sv
// behavioural regulators on the far side of the sequencer
// assumes enables and levels come straight from the sequencer
`timescale 1ns/1ns
`default_nettype none
module pss_rail_model (
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire pss_pkg::pss_rail_en_t rail_en,
  input wire pss_pkg::pss_level_t   rail_level,
  output pss_pkg::pss_rail_en_t     rail_up,
  output logic                      level_err
);
  import pss_pkg::*;
  pss_rail_en_t no_lvl;  // rails with a zero target
  // a regulator enabled with no target level still starts but sets level_err
  always_comb begin
    for (int i = 0; i < NRAIL; i++) no_lvl[i] = (rail_level[i] == 16'h0);
  end
  // soft start: a rail is in range one edge after its enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rail_up   <= '0;
      level_err <= 1'b0;
    end else begin
      rail_up   <= rail_en;
      level_err <= level_err | (|(rail_en & no_lvl));
    end
  end
endmodule // pss_rail_model
`default_nettype wire

// >>> testbench/pss_startup_sequencer_tb.sv
// self-checking bench of the start-up sequencer
// assumes the checker binds itself and a short tap interval
`timescale 1ns/1ns
`default_nettype none
module pss_startup_sequencer_tb;
  import pss_pkg::*;
  localparam int unsigned TP = 8;  // short taps keep the run brief
  // per-rail tap, second strap grounded / otherwise; 99 = never
  localparam int TG[NRAIL] = '{5,0,7,2,4,4,9,6,8,3,99,1,99,3,99,99,99};
  localparam int TO[NRAIL] = '{4,0,5,1,99,9,9,6,7,2,99,3,99,99,99,99,99};
  logic             mclk, rst_n, vbus, backup, pg, done, lerr;
  pss_strap_sense_t sa, sb;
  pss_pre_rails_t   pre;
  pss_rail_en_t     en, up;
  pss_level_t       lvl;
  logic [3:0]       skip, tap;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  pss_startup_sequencer #(.TAP_CYCLES_P(TP)) DUT (.mclk(mclk),
    .rst_n(rst_n), .startup_strap_a(sa), .startup_strap_b(sb),
    .bus_voltage_sense(vbus), .backup_cell_valid(backup),
    .pre_rails(pre), .rail_en(en), .rail_level(lvl),
    .buck_pulse_skip(skip), .power_gate_en(pg), .tap_index(tap),
    .seq_done(done));
  pss_rail_model MODEL (.mclk(mclk), .rst_n(rst_n), .rail_en(en),
    .rail_level(lvl), .rail_up(up), .level_err(lerr));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog: the whole run needs about 480 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      $display("unexpected at %0t: run hung", $time);
      end_of_test();
    end
  end
  task automatic check(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  // pad sensing for a strap code
  function automatic pss_strap_sense_t sense(logic [1:0] c);
    case (c)
      STRAP_GND:  return 3'h4;
      STRAP_AON:  return 3'h2;
      STRAP_CORE: return 3'h1;
      default:    return 3'h0;
    endcase
  endfunction
  // rails expected on once tap k has passed
  function automatic pss_rail_en_t want(logic bg, vb, gb, int k);
    pss_rail_en_t m;
    m = '0;
    for (int i = 0; i < NRAIL; i++) begin
      if ((bg ? TG[i] : TO[i]) <= k) m[i] = 1'b1;
    end
    if (!bg && !vb) m[RAIL_USB_XCVR] = 1'b0;
    if (!gb) m[RAIL_GEN_B] = 1'b0;
    return m;
  endfunction
  // one power-up from reset; flip moves the straps after capture
  task automatic run(input logic [1:0] a, b, input logic vb, flip);
    logic bg, gb;
    int e;
    logic [15:0] two;
    logic [15:0] one;
    logic [15:0] thr;
    logic [15:0] pll_mv;
    bg = (b == STRAP_GND);
    one = bg ? 16'h04B0
             : (a == STRAP_GND || a == STRAP_CORE ? 16'h0307 : 16'h041A);
    thr = bg ? 16'h0708 : 16'h04B0;
    pll_mv = bg ? 16'h05DC : 16'h0708;
    gb = bg || a == STRAP_GND || a == STRAP_AON;
    two = bg ? (a == STRAP_GND ? 16'h0546 : 16'h05AA)
             : (a == STRAP_GND || a == STRAP_CORE ? 16'h0401 : 16'h04C9);
    @(posedge mclk);
    rst_n <= 1'b0;
    sa <= sense(a);
    sb <= sense(b);
    vbus <= vb;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    e = 0;
    for (int k = 0; k <= 9; k++) begin
      while (e < 6 + TP * k) begin
        @(posedge mclk);
        e++;
        if (e == 6 && flip) sa <= sense(STRAP_GND);
        if (e == 6 && flip) sb <= sense(STRAP_GND);
        #1;
        if (e == 5) check(pre === 3'h0, "pre rails early");
        if (e == 6) check(pre === 3'h7, "pre rails missing");
      end
      check(en === want(bg, vb, gb, k - 1), "rail early");
      @(posedge mclk);
      e++;
      #1;
      check(en === want(bg, vb, gb, k), "rail late");
    end
    repeat (11) @(posedge mclk);
    backup <= 1'b0;
    #1;
    check(done === 1'b1 && tap === 4'h9, "no done at tap 9");
    check(skip === 4'hF && pg === 1'b0, "buck mode or gate");
    check(lerr === 1'b0 && up === en, "regulator view");
    check(lvl[RAIL_BUCK_TWO] === two, "buck two level");
    check(lvl[RAIL_BUCK_FOUR] === 16'h0708, "buck four level");
    check(lvl[RAIL_BUCK_ONE] === one, "buck one level");
    check(lvl[RAIL_BUCK_THR] === thr, "buck three level");
    check(lvl[RAIL_PLL] === pll_mv, "pll level");
    check(lvl[RAIL_LOW_DIG] === 16'h04E2, "low digital level");
    check(lvl[RAIL_IO_HIGH] === 16'h0AD7, "io high level");
    check(lvl[RAIL_USB_XCVR] === 16'h0CE4, "usb xcvr level");
    check(lvl[RAIL_USB_PHY] === 16'h0A28, "usb phy level");
    check(lvl[RAIL_BOOST] === (bg ? 16'h1388 : 16'h0), "boost");
    check(lvl[RAIL_CARD] === (bg ? 16'h0C4E : 16'h0), "card");
    check(lvl[RAIL_GEN_B] === (gb ? 16'h0C4E : 16'h0), "gen b");
    check(lvl[RAIL_CAMERA] === 16'h0, "camera level");
    repeat (3) @(posedge mclk);
    backup <= 1'b1;
    #1;
    check(pre === 3'h3, "always-on rail without backup");
  endtask
  task automatic sc_open_b_vbus();
    run(STRAP_GND, STRAP_OPEN, 1'b1, 1'b0);
    $display("test open second strap with bus done");
  endtask
  task automatic sc_open_b_novbus();
    run(STRAP_OPEN, STRAP_OPEN, 1'b0, 1'b0);
    $display("test open straps without bus done");
  endtask
  task automatic sc_gnd_b();
    run(STRAP_OPEN, STRAP_GND, 1'b0, 1'b0);
    $display("test grounded second strap done");
  endtask
  task automatic sc_late_change();
    run(STRAP_CORE, STRAP_AON, 1'b1, 1'b1);
    $display("test strap change after capture done");
  endtask
  task automatic sc_aon_gnd();
    run(STRAP_AON, STRAP_GND, 1'b1, 1'b0);
    $display("test always-on first strap done");
  endtask
  initial begin
    rst_n = 1'b0;
    sa = 3'h0;
    sb = 3'h0;
    vbus = 1'b0;
    backup = 1'b1;
    sc_open_b_vbus();
    sc_open_b_novbus();
    sc_gnd_b();
    sc_late_change();
    sc_aon_gnd();
    end_of_test();
  end
endmodule // pss_startup_sequencer_tb
`default_nettype wire
